// ==== shared/serial_bus_pkg.sv ====
// Constants, field layout and carrier types for the serial bus status block
package serial_bus_pkg;

	// Register byte offsets on the Avalon-MM slave
	localparam logic [4:0] OFS_STATUS = 5'h00;
	localparam logic [4:0] OFS_CONTROL = 5'h04;
	localparam logic [4:0] OFS_OWN_ADDR = 5'h08;
	localparam logic [4:0] OFS_TX_HOLD = 5'h0C;
	localparam logic [4:0] OFS_RX_HOLD = 5'h10;
	localparam logic [4:0] OFS_IRQ_STATUS = 5'h14;
	localparam logic [4:0] OFS_IRQ_MASK = 5'h18;

	// Status register field positions
	localparam int ST_ACK_MISSING = 15;
	localparam int ST_TX_ACTIVE = 14;
	localparam int ST_COLLISION = 10;
	localparam int ST_GENERAL_CALL = 9;
	localparam int ST_TEN_BIT = 8;
	localparam int ST_WRITE_COLL = 7;
	localparam int ST_RX_OVERFLOW = 6;
	localparam int ST_DATA_ADDR = 5;
	localparam int ST_STOP_SEEN = 4;
	localparam int ST_START_SEEN = 3;
	localparam int ST_READ_DIR = 2;
	localparam int ST_RX_FULL = 1;
	localparam int ST_TX_FULL = 0;

	// Control register field positions
	localparam int CTL_ON = 0;
	localparam int CTL_TEN_BIT_MODE = 1;
	localparam int CTL_GC_ENABLE = 2;

	// Interrupt status and mask field positions
	localparam int IRQ_ACK_SLOT = 0;
	localparam int IRQ_COLLISION = 1;
	localparam int IRQ_ADDR_MATCH = 2;
	localparam int IRQ_RX_BYTE = 3;
	localparam int IRQ_OVERFLOW = 4;
	localparam int IRQ_WRITE_COLL = 5;
	localparam int IRQ_STOP = 6;
	localparam int IRQ_WIDTH = 7;

	// Byte framing on the link
	localparam logic [3:0] LAST_DATA_BIT = 4'h7;
	localparam logic [3:0] ACK_BIT = 4'h8;
	localparam logic [4:0] TEN_BIT_PREFIX = 5'h1E;
	localparam logic [7:0] GENERAL_CALL_ADDR = 8'h00;

	// Reset values
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
	localparam logic [9:0] OWN_ADDR_RESET = 10'h000;

	// Conditions seen on the two synchronised wires
	typedef struct packed {
		logic sclRise;
		logic start;
		logic stop;
		logic sdaLevel;
	} bus_events_t;

	// Slave address phase tracking
	typedef enum logic [2:0] {
		PH_IDLE = 3'b000,
		PH_FIRST = 3'b001,
		PH_SECOND = 3'b010,
		PH_DATA = 3'b011,
		PH_IGNORE = 3'b100
	} addr_phase_t;

endpackage

// ==== logic/bus_line_monitor.sv ====
// Two-flop sampling of the bus wires and start, stop and clock edge detection
module bus_line_monitor (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Raw bus wires
	input wire logic sclIn,
	input wire logic sdaIn,
	// Decoded conditions
	output serial_bus_pkg::bus_events_t events
);

	logic sclMeta_reg;
	logic sdaMeta_reg;
	logic sclSync_reg;
	logic sdaSync_reg;
	logic sclLast_reg;
	logic sdaLast_reg;

	// Synchronisers; wires idle high so reset to one
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sclMeta_reg <= 1'b1;
			sdaMeta_reg <= 1'b1;
			sclSync_reg <= 1'b1;
			sdaSync_reg <= 1'b1;
		end else begin
			sclMeta_reg <= sclIn;
			sdaMeta_reg <= sdaIn;
			sclSync_reg <= sclMeta_reg;
			sdaSync_reg <= sdaMeta_reg;
		end
	end

	// Delayed copies for edge finding, fed only from the second stage
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sclLast_reg <= 1'b1;
			sdaLast_reg <= 1'b1;
		end else begin
			sclLast_reg <= sclSync_reg;
			sdaLast_reg <= sdaSync_reg;
		end
	end

	// Data moving while the clock is high marks start or stop
	always_comb begin
		events.sclRise = sclSync_reg & ~sclLast_reg;
		events.start = sclSync_reg & sclLast_reg & sdaLast_reg & ~sdaSync_reg;
		events.stop = sclSync_reg & sclLast_reg & ~sdaLast_reg & sdaSync_reg;
		events.sdaLevel = sdaSync_reg;
	end

endmodule

// ==== logic/serial_bus_status.sv ====
// Status flags, holding registers and Avalon-MM slave of the two-wire bus controller
//
// The placing of the registers and the Avalon-MM interface to the registers were chosen for this implementation.

module serial_bus_status (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Avalon-MM register slave
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Interrupt
	output logic irq,
	// Bus wires, sampled
	input wire logic sclIn,
	input wire logic sdaIn,
	// Controller core on the same clock
	input wire logic masterTxStart,
	input wire logic masterActive,
	input wire logic sdaDriveLow,
	input wire logic moduleBusy,
	input wire logic txTake,
	// Towards the controller core
	output logic moduleOn,
	output logic [7:0] txData,
	output logic txFull
);

	serial_bus_pkg::bus_events_t ev;
	serial_bus_pkg::addr_phase_t phase_reg;
	serial_bus_pkg::addr_phase_t phase_next;

	logic ackPending_reg;
	logic accept;
	logic wrAccept;
	logic [31:0] readWord;
	logic [31:0] statusWord;
	logic [3:0] bitCount_reg;
	logic [7:0] shift_reg;
	logic [7:0] byteNow;
	logic byteDone;
	logic ackSlot;
	logic ctlOn_reg;
	logic tenBitMode_reg;
	logic gcEnable_reg;
	logic [9:0] ownAddr_reg;
	logic ackMissing_reg;
	logic txActive_reg;
	logic collision_reg;
	logic generalCall_reg;
	logic tenBitMatch_reg;
	logic writeColl_reg;
	logic rxOverflow_reg;
	logic dataAddr_reg;
	logic startSeen_reg;
	logic stopSeen_reg;
	logic readDir_reg;
	logic [7:0] rxHold_reg;
	logic rxFull_reg;
	logic [7:0] txHold_reg;
	logic txFull_reg;
	logic [serial_bus_pkg::IRQ_WIDTH-1:0] irqStatus_reg;
	logic [serial_bus_pkg::IRQ_WIDTH-1:0] irqMask_reg;
	logic [serial_bus_pkg::IRQ_WIDTH-1:0] irqEvents;
	logic collisionNow;
	logic addrMatch;
	logic gcMatch;
	logic tenMatch;
	logic dataByte;
	logic slaveByte;
	logic txWriteTry;
	logic rxHoldRead;
	logic [31:0] clearMask;

	bus_line_monitor lineMonitor (
		.clk(clk),
		.rst_n(rst_n),
		.sclIn(sclIn),
		.sdaIn(sdaIn),
		.events(ev)
	);

	// Register access helper: true when an accepted write hits the offset
	function automatic logic hitWrite(input logic [4:0] ofs);
		hitWrite = wrAccept && (avs_address == ofs);
	endfunction

	// One wait state per access so read data can come from a flop
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ackPending_reg <= 1'b0;
		end else begin
			ackPending_reg <= (avs_read | avs_write) & ~ackPending_reg;
		end
	end

	assign avs_waitrequest = (avs_read | avs_write) & ~ackPending_reg;
	assign accept = (avs_read | avs_write) & ackPending_reg;
	assign wrAccept = accept & avs_write;
	assign rxHoldRead = accept & avs_read & (avs_address == serial_bus_pkg::OFS_RX_HOLD);
	assign txWriteTry = hitWrite(serial_bus_pkg::OFS_TX_HOLD);
	assign clearMask = hitWrite(serial_bus_pkg::OFS_STATUS) ? avs_writedata : serial_bus_pkg::WORD_ZERO;

	// Status word; every bit not assigned stays zero
	always_comb begin
		statusWord = serial_bus_pkg::WORD_ZERO;
		statusWord[serial_bus_pkg::ST_ACK_MISSING] = ackMissing_reg;
		statusWord[serial_bus_pkg::ST_TX_ACTIVE] = txActive_reg;
		statusWord[serial_bus_pkg::ST_COLLISION] = collision_reg;
		statusWord[serial_bus_pkg::ST_GENERAL_CALL] = generalCall_reg;
		statusWord[serial_bus_pkg::ST_TEN_BIT] = tenBitMatch_reg;
		statusWord[serial_bus_pkg::ST_WRITE_COLL] = writeColl_reg;
		statusWord[serial_bus_pkg::ST_RX_OVERFLOW] = rxOverflow_reg;
		statusWord[serial_bus_pkg::ST_DATA_ADDR] = dataAddr_reg;
		statusWord[serial_bus_pkg::ST_STOP_SEEN] = stopSeen_reg;
		statusWord[serial_bus_pkg::ST_START_SEEN] = startSeen_reg;
		statusWord[serial_bus_pkg::ST_READ_DIR] = readDir_reg;
		statusWord[serial_bus_pkg::ST_RX_FULL] = rxFull_reg;
		statusWord[serial_bus_pkg::ST_TX_FULL] = txFull_reg;
	end

	// Read multiplexer; unmapped offsets read as zero
	always_comb begin
		readWord = serial_bus_pkg::WORD_ZERO;
		unique case (avs_address)
			serial_bus_pkg::OFS_STATUS: readWord = statusWord;
			serial_bus_pkg::OFS_CONTROL: begin
				readWord[serial_bus_pkg::CTL_ON] = ctlOn_reg;
				readWord[serial_bus_pkg::CTL_TEN_BIT_MODE] = tenBitMode_reg;
				readWord[serial_bus_pkg::CTL_GC_ENABLE] = gcEnable_reg;
			end
			serial_bus_pkg::OFS_OWN_ADDR: readWord[9:0] = ownAddr_reg;
			serial_bus_pkg::OFS_TX_HOLD: readWord[7:0] = txHold_reg;
			serial_bus_pkg::OFS_RX_HOLD: readWord[7:0] = rxHold_reg;
			serial_bus_pkg::OFS_IRQ_STATUS: readWord[serial_bus_pkg::IRQ_WIDTH-1:0] = irqStatus_reg;
			serial_bus_pkg::OFS_IRQ_MASK: readWord[serial_bus_pkg::IRQ_WIDTH-1:0] = irqMask_reg;
			default: readWord = serial_bus_pkg::WORD_ZERO;
		endcase
	end

	// Read data captured in the wait-state cycle, held for the accepting edge
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			avs_readdata <= serial_bus_pkg::WORD_ZERO;
		end else if (avs_read && !ackPending_reg) begin
			avs_readdata <= readWord;
		end
	end

	// Control and own address registers
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ctlOn_reg <= 1'b0;
			tenBitMode_reg <= 1'b0;
			gcEnable_reg <= 1'b0;
			ownAddr_reg <= serial_bus_pkg::OWN_ADDR_RESET;
		end else begin
			if (hitWrite(serial_bus_pkg::OFS_CONTROL)) begin
				ctlOn_reg <= avs_writedata[serial_bus_pkg::CTL_ON];
				tenBitMode_reg <= avs_writedata[serial_bus_pkg::CTL_TEN_BIT_MODE];
				gcEnable_reg <= avs_writedata[serial_bus_pkg::CTL_GC_ENABLE];
			end
			if (hitWrite(serial_bus_pkg::OFS_OWN_ADDR)) begin
				ownAddr_reg <= avs_writedata[9:0];
			end
		end
	end

	assign moduleOn = ctlOn_reg;

	// Bit counter, restarted by each start condition, and shifter
	always_ff @(posedge clk) begin
		if (!rst_n || !ctlOn_reg) begin
			bitCount_reg <= 4'h0;
			shift_reg <= 8'h00;
		end else if (ev.start) begin
			bitCount_reg <= 4'h0;
		end else if (ev.sclRise) begin
			shift_reg <= {shift_reg[6:0], ev.sdaLevel};
			bitCount_reg <= (bitCount_reg == serial_bus_pkg::ACK_BIT) ? 4'h0 : bitCount_reg + 4'h1;
		end
	end

	assign byteNow = {shift_reg[6:0], ev.sdaLevel};
	assign byteDone = ev.sclRise & (bitCount_reg == serial_bus_pkg::LAST_DATA_BIT);
	assign ackSlot = ev.sclRise & (bitCount_reg == serial_bus_pkg::ACK_BIT);
	assign slaveByte = byteDone & ~masterActive;

	// Address decoding on completed slave bytes
	always_comb begin
		phase_next = phase_reg;
		addrMatch = 1'b0;
		gcMatch = 1'b0;
		tenMatch = 1'b0;
		dataByte = 1'b0;
		unique case (phase_reg)
			serial_bus_pkg::PH_IDLE: begin
			end
			serial_bus_pkg::PH_FIRST: begin
				if (slaveByte) begin
					if (gcEnable_reg && byteNow == serial_bus_pkg::GENERAL_CALL_ADDR) begin
						gcMatch = 1'b1;
						addrMatch = 1'b1;
						phase_next = serial_bus_pkg::PH_DATA;
					end else if (tenBitMode_reg && byteNow[7:3] == serial_bus_pkg::TEN_BIT_PREFIX
							&& byteNow[2:1] == ownAddr_reg[9:8]) begin
						phase_next = serial_bus_pkg::PH_SECOND;
					end else if (!tenBitMode_reg && byteNow[7:1] == ownAddr_reg[6:0]) begin
						addrMatch = 1'b1;
						phase_next = serial_bus_pkg::PH_DATA;
					end else begin
						phase_next = serial_bus_pkg::PH_IGNORE;
					end
				end
			end
			serial_bus_pkg::PH_SECOND: begin
				if (slaveByte) begin
					if (byteNow == ownAddr_reg[7:0]) begin
						tenMatch = 1'b1;
						addrMatch = 1'b1;
						phase_next = serial_bus_pkg::PH_DATA;
					end else begin
						phase_next = serial_bus_pkg::PH_IGNORE;
					end
				end
			end
			serial_bus_pkg::PH_DATA: dataByte = slaveByte;
			serial_bus_pkg::PH_IGNORE: begin
			end
			default: phase_next = serial_bus_pkg::PH_IDLE;
		endcase
		if (ev.start) begin
			phase_next = serial_bus_pkg::PH_FIRST;
		end else if (ev.stop) begin
			phase_next = serial_bus_pkg::PH_IDLE;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n || !ctlOn_reg) begin
			phase_reg <= serial_bus_pkg::PH_IDLE;
		end else begin
			phase_reg <= phase_next;
		end
	end

	// Master transmit progress and acknowledge result
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			txActive_reg <= 1'b0;
			ackMissing_reg <= 1'b0;
		end else if (masterTxStart) begin
			txActive_reg <= 1'b1;
		end else if (txActive_reg && ackSlot) begin
			ackMissing_reg <= ev.sdaLevel;
			txActive_reg <= 1'b0;
		end
	end

	// Released line read back low during our own data bits means we lost
	assign collisionNow = masterActive & ev.sclRise & ~sdaDriveLow & ~ev.sdaLevel
		& (bitCount_reg != serial_bus_pkg::ACK_BIT);

	// Collision flag: only the module being off clears it, not a status write
	always_ff @(posedge clk) begin
		if (!rst_n || !ctlOn_reg) begin
			collision_reg <= 1'b0;
		end else if (collisionNow) begin
			collision_reg <= 1'b1;
		end
	end

	// Address kind flags set on the match, data flag cleared by a match and set by a data byte; general call and ten-bit dropped by stop
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			generalCall_reg <= 1'b0;
			tenBitMatch_reg <= 1'b0;
			dataAddr_reg <= 1'b0;
			readDir_reg <= 1'b0;
		end else begin
			if (gcMatch) begin
				generalCall_reg <= 1'b1;
			end else if (ev.stop) begin
				generalCall_reg <= 1'b0;
			end
			if (tenMatch) begin
				tenBitMatch_reg <= 1'b1;
			end else if (ev.stop) begin
				tenBitMatch_reg <= 1'b0;
			end
			if (addrMatch) begin
				dataAddr_reg <= 1'b0;
			end else if (dataByte) begin
				dataAddr_reg <= 1'b1;
			end
			if (slaveByte && phase_reg == serial_bus_pkg::PH_FIRST) begin
				readDir_reg <= byteNow[0];
			end
		end
	end

	// Start and stop indications, each cancelling the other
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			startSeen_reg <= 1'b0;
			stopSeen_reg <= 1'b0;
		end else if (ev.start) begin
			startSeen_reg <= 1'b1;
			stopSeen_reg <= 1'b0;
		end else if (ev.stop) begin
			startSeen_reg <= 1'b0;
			stopSeen_reg <= 1'b1;
		end
	end

	// Receive holding register; an unread byte is kept and the new one lost
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rxHold_reg <= 8'h00;
			rxFull_reg <= 1'b0;
			rxOverflow_reg <= 1'b0;
		end else begin
			if (dataByte && rxFull_reg) begin
				rxOverflow_reg <= 1'b1;
			end else if (clearMask[serial_bus_pkg::ST_RX_OVERFLOW]) begin
				rxOverflow_reg <= 1'b0;
			end
			if (dataByte && !rxFull_reg) begin
				rxHold_reg <= byteNow;
				rxFull_reg <= 1'b1;
			end else if (rxHoldRead) begin
				rxFull_reg <= 1'b0;
			end
		end
	end

	// Transmit holding register; a write while busy is dropped and flagged
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			txHold_reg <= 8'h00;
			txFull_reg <= 1'b0;
			writeColl_reg <= 1'b0;
		end else begin
			if (txWriteTry && moduleBusy) begin
				writeColl_reg <= 1'b1;
			end else if (clearMask[serial_bus_pkg::ST_WRITE_COLL]) begin
				writeColl_reg <= 1'b0;
			end
			if (txWriteTry && !moduleBusy) begin
				txHold_reg <= avs_writedata[7:0];
				txFull_reg <= 1'b1;
			end else if (txTake) begin
				txFull_reg <= 1'b0;
			end
		end
	end

	assign txData = txHold_reg;
	assign txFull = txFull_reg;

	// Event sources for the interrupt status
	always_comb begin
		irqEvents = '0;
		irqEvents[serial_bus_pkg::IRQ_ACK_SLOT] = txActive_reg & ackSlot;
		irqEvents[serial_bus_pkg::IRQ_COLLISION] = collisionNow;
		irqEvents[serial_bus_pkg::IRQ_ADDR_MATCH] = addrMatch;
		irqEvents[serial_bus_pkg::IRQ_RX_BYTE] = dataByte & ~rxFull_reg;
		irqEvents[serial_bus_pkg::IRQ_OVERFLOW] = dataByte & rxFull_reg;
		irqEvents[serial_bus_pkg::IRQ_WRITE_COLL] = txWriteTry & moduleBusy;
		irqEvents[serial_bus_pkg::IRQ_STOP] = ev.stop & ctlOn_reg;
	end

	// Sticky interrupt bits, write one to clear; a new event beats the clear
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			irqStatus_reg <= '0;
			irqMask_reg <= '0;
		end else begin
			if (hitWrite(serial_bus_pkg::OFS_IRQ_STATUS)) begin
				irqStatus_reg <= (irqStatus_reg & ~avs_writedata[serial_bus_pkg::IRQ_WIDTH-1:0])
					| irqEvents;
			end else begin
				irqStatus_reg <= irqStatus_reg | irqEvents;
			end
			if (hitWrite(serial_bus_pkg::OFS_IRQ_MASK)) begin
				irqMask_reg <= avs_writedata[serial_bus_pkg::IRQ_WIDTH-1:0];
			end
		end
	end

	assign irq = |(irqStatus_reg & irqMask_reg);

endmodule

// ==== testbench/serial_bus_status_sva.sv ====
// Bus timing and holding register checker for the status block
module serial_bus_status_sva (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Register bus
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	// Interrupt and controller side
	input wire logic irq,
	input wire logic moduleBusy,
	input wire logic txTake,
	input wire logic moduleOn,
	input wire logic [7:0] txData,
	input wire logic txFull
);
	timeunit 1ns;
	timeprecision 1ns;
	logic rdOk;
	logic wrOk;
	// Accepted accesses, so each property names its cause once
	assign rdOk = avs_read && !avs_waitrequest;
	assign wrOk = avs_write && !avs_waitrequest;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("access not answered after one wait state");
	wait_idle_a: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
		else $error("wait raised with no access");
	status_gaps_a: assert property (rdOk && avs_address == serial_bus_pkg::OFS_STATUS
		|-> avs_readdata[31:16] == 16'h0000 && avs_readdata[13:11] == 3'h0)
		else $error("unused status bits not zero");
	unmapped_zero_a: assert property (rdOk && avs_address > serial_bus_pkg::OFS_IRQ_MASK
		|-> avs_readdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	tx_load_a: assert property (wrOk && avs_address == serial_bus_pkg::OFS_TX_HOLD && !moduleBusy
		|=> txFull && txData == $past(avs_writedata[7:0]))
		else $error("idle transmit write not loaded");
	tx_refuse_a: assert property (wrOk && avs_address == serial_bus_pkg::OFS_TX_HOLD
		&& moduleBusy && !txTake |=> $stable(txData) && $stable(txFull))
		else $error("busy transmit write took effect");
	tx_take_a: assert property (txTake && !(avs_write && avs_address == serial_bus_pkg::OFS_TX_HOLD)
		|=> !txFull)
		else $error("transmit byte taken but still full");
	on_follow_a: assert property (wrOk && avs_address == serial_bus_pkg::OFS_CONTROL
		|=> moduleOn == $past(avs_writedata[0]))
		else $error("module enable not following control write");
	irq_reset_a: assert property ($rose(rst_n) |-> !irq)
		else $error("interrupt high after reset");
endmodule

bind serial_bus_status serial_bus_status_sva serial_bus_status_sva_inst (
	.clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .irq(irq), .moduleBusy(moduleBusy), .txTake(txTake),
	.moduleOn(moduleOn), .txData(txData), .txFull(txFull)
);

// ==== testbench/bus_agent.sv ====
// Other agent on the two-wire bus, clocking and framing bytes
module bus_agent (
	// Clock
	input wire logic clk,
	// Device pull on the data wire
	input wire logic sdaDriveLow,
	// Wires seen by the device
	output logic sclIn,
	output logic sdaIn
);
	timeunit 1ns;
	timeprecision 1ns;
	logic sclDrive = 1'b1;
	logic sdaOut = 1'b1;
	// Wired-and with pull-up: either party can win low
	assign sdaIn = sdaOut & ~sdaDriveLow;
	assign sclIn = sclDrive;
	task waitClk(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Clock stands high between frames
	task sendStart;
		sdaOut <= 1'b0;
		waitClk(4);
		sclDrive <= 1'b0;
		waitClk(2);
	endtask
	// Data line released after each bit, so no stale level lingers
	task sendBit(input logic b);
		sdaOut <= b;
		waitClk(2);
		sclDrive <= 1'b1;
		waitClk(4);
		sclDrive <= 1'b0;
		sdaOut <= 1'b1;
		waitClk(2);
	endtask
	// Bytes arrive whether or not the last one was read
	task sendByte(input logic [7:0] v, input logic ack);
		for (int i = 7; i >= 0; i--) begin
			sendBit(v[i]);
		end
		sendBit(ack);
	endtask
	task sendStop;
		sdaOut <= 1'b0;
		waitClk(2);
		sclDrive <= 1'b1;
		waitClk(2);
		sdaOut <= 1'b1;
		waitClk(4);
	endtask
endmodule

// ==== testbench/serial_bus_status_test.sv ====
// Register-level tests of the status flag block
module serial_bus_status_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [4:0] avs_address = 5'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic masterTxStart = 1'b0;
	logic masterActive = 1'b0;
	logic sdaDriveLow = 1'b0;
	logic moduleBusy = 1'b0;
	logic txTake = 1'b0;
	logic [31:0] avs_readdata;
	logic [31:0] rdata;
	logic [7:0] txData;
	logic avs_waitrequest, irq, sclIn, sdaIn, moduleOn, txFull;
	int nErrors = 0;
	int totalChecks = 0;

	// 10 MHz system clock
	always #50 clk = ~clk;

	serial_bus_status serial_bus_status_inst (.clk(clk), .rst_n(rst_n),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .irq(irq), .sclIn(sclIn), .sdaIn(sdaIn),
		.masterTxStart(masterTxStart), .masterActive(masterActive), .sdaDriveLow(sdaDriveLow),
		.moduleBusy(moduleBusy), .txTake(txTake), .moduleOn(moduleOn), .txData(txData),
		.txFull(txFull));
	bus_agent bus_agent_inst (.clk(clk), .sdaDriveLow(sdaDriveLow), .sclIn(sclIn), .sdaIn(sdaIn));

	task chk(input string name, input logic [31:0] expv, input logic [31:0] seen);
		totalChecks++;
		if (seen !== expv) begin
			nErrors++;
			$display("BAD %s expected %h seen %h", name, expv, seen);
		end
	endtask
	// One access, entered after a rising edge; held until waitrequest is sampled low
	task acc(input logic wr, input logic [4:0] addr, input logic [31:0] data);
		avs_address <= addr;
		avs_writedata <= data;
		avs_write <= wr;
		avs_read <= ~wr;
		@(posedge clk);
		while (avs_waitrequest !== 1'b0) @(posedge clk);
		rdata = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clk);
	endtask
	task rc(input logic [4:0] addr, input logic [31:0] mask, input logic [31:0] expv);
		acc(1'b0, addr, 32'h0000_0000);
		chk($sformatf("reg %h", addr), expv, rdata & mask);
	endtask
	// One-cycle start of a master byte from the controller
	task pulseStart;
		masterTxStart <= 1'b1;
		@(posedge clk);
		masterTxStart <= 1'b0;
		@(posedge clk);
	endtask
	task finishTest;
		$display("checks %0d errors %0d", totalChecks, nErrors);
		if (nErrors == 0 && totalChecks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Cut a hung run short
	initial begin
		repeat (30000) @(posedge clk);
		nErrors++;
		finishTest;
	end

	// Main sequence
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rc(serial_bus_pkg::OFS_STATUS, 32'hFFFF_FFFF, 32'h0000_0000);
		rc(5'h1C, 32'hFFFF_FFFF, 32'h0000_0000);
		acc(1'b1, serial_bus_pkg::OFS_STATUS, 32'hFFFF_FFFF);
		rc(serial_bus_pkg::OFS_STATUS, 32'hFFFF_FFFF, 32'h0000_0000);
		// Master transmit, acknowledged then not
		acc(1'b1, serial_bus_pkg::OFS_CONTROL, 32'h0000_0001);
		chk("moduleOn", 32'h1, {31'h0, moduleOn});
		masterActive <= 1'b1;
		bus_agent_inst.sendStart;
		pulseStart;
		rc(serial_bus_pkg::OFS_STATUS, 32'h0000_C000, 32'h0000_4000);
		bus_agent_inst.sendByte(8'hFF, 1'b0);
		rc(serial_bus_pkg::OFS_STATUS, 32'h0000_C400, 32'h0000_0000);
		pulseStart;
		bus_agent_inst.sendByte(8'hFF, 1'b1);
		rc(serial_bus_pkg::OFS_STATUS, 32'h0000_C000, 32'h0000_8000);
		rc(serial_bus_pkg::OFS_IRQ_STATUS, 32'h0000_0001, 32'h0000_0001);
		// Collision: another master pulls data low while device releases it
		// Own pull on the data wire is no collision
		pulseStart;
		sdaDriveLow <= 1'b1;
		bus_agent_inst.sendByte(8'h00, 1'b0);
		sdaDriveLow <= 1'b0;
		rc(serial_bus_pkg::OFS_STATUS, 32'h0000_0400, 32'h0000_0000);
		pulseStart;
		bus_agent_inst.sendByte(8'h00, 1'b0);
		bus_agent_inst.sendStop;
		rc(serial_bus_pkg::OFS_STATUS, 32'h0000_0400, 32'h0000_0400);
		chk("irq", 32'h0, {31'h0, irq});
		acc(1'b1, serial_bus_pkg::OFS_IRQ_MASK, 32'h0000_0002);
		chk("irq", 32'h1, {31'h0, irq});
		acc(1'b1, serial_bus_pkg::OFS_IRQ_STATUS, 32'h0000_0002);
		chk("irq", 32'h0, {31'h0, irq});
		acc(1'b1, serial_bus_pkg::OFS_STATUS, 32'h0000_0400);
		rc(serial_bus_pkg::OFS_STATUS, 32'h0000_0400, 32'h0000_0400);
		acc(1'b1, serial_bus_pkg::OFS_CONTROL, 32'h0000_0000);
		acc(1'b1, serial_bus_pkg::OFS_CONTROL, 32'h0000_0001);
		rc(serial_bus_pkg::OFS_STATUS, 32'h0000_0400, 32'h0000_0000);
		masterActive <= 1'b0;
		// Slave: general call, then two data bytes left unread
		acc(1'b1, serial_bus_pkg::OFS_CONTROL, 32'h0000_0005);
		bus_agent_inst.sendStart;
		bus_agent_inst.sendByte(8'h00, 1'b1);
		rc(serial_bus_pkg::OFS_STATUS, 32'h0000_0260, 32'h0000_0200);
		bus_agent_inst.sendByte(8'h5A, 1'b1);
		rc(serial_bus_pkg::OFS_STATUS, 32'h0000_0260, 32'h0000_0220);
		acc(1'b1, serial_bus_pkg::OFS_STATUS, 32'hFFFF_FF3F);
		rc(serial_bus_pkg::OFS_STATUS, 32'h0000_0260, 32'h0000_0220);
		bus_agent_inst.sendByte(8'h3C, 1'b1);
		rc(serial_bus_pkg::OFS_STATUS, 32'h0000_0040, 32'h0000_0040);
		rc(serial_bus_pkg::OFS_RX_HOLD, 32'h0000_00FF, 32'h0000_005A);
		acc(1'b1, serial_bus_pkg::OFS_STATUS, 32'h0000_0040);
		rc(serial_bus_pkg::OFS_STATUS, 32'h0000_0040, 32'h0000_0000);
		bus_agent_inst.sendStop;
		rc(serial_bus_pkg::OFS_STATUS, 32'h0000_0200, 32'h0000_0000);
		// Slave: ten-bit address match
		acc(1'b1, serial_bus_pkg::OFS_OWN_ADDR, 32'h0000_02A5);
		acc(1'b1, serial_bus_pkg::OFS_CONTROL, 32'h0000_0003);
		bus_agent_inst.sendStart;
		bus_agent_inst.sendByte(8'hF4, 1'b1);
		bus_agent_inst.sendByte(8'hA5, 1'b1);
		rc(serial_bus_pkg::OFS_STATUS, 32'h0000_0120, 32'h0000_0100);
		bus_agent_inst.sendStop;
		rc(serial_bus_pkg::OFS_STATUS, 32'h0000_0100, 32'h0000_0000);
		// Slave: seven-bit address match, then one data byte
		acc(1'b1, serial_bus_pkg::OFS_CONTROL, 32'h0000_0001);
		bus_agent_inst.sendStart;
		bus_agent_inst.sendByte(8'h4A, 1'b1);
		bus_agent_inst.sendByte(8'h11, 1'b1);
		rc(serial_bus_pkg::OFS_STATUS, 32'h0000_0022, 32'h0000_0022);
		rc(serial_bus_pkg::OFS_RX_HOLD, 32'h0000_00FF, 32'h0000_0011);
		bus_agent_inst.sendStop;
		// Transmit holding writes, busy then idle
		moduleBusy <= 1'b1;
		acc(1'b1, serial_bus_pkg::OFS_TX_HOLD, 32'h0000_003C);
		chk("txFull", 32'h0, {31'h0, txFull});
		rc(serial_bus_pkg::OFS_STATUS, 32'h0000_0080, 32'h0000_0080);
		acc(1'b1, serial_bus_pkg::OFS_STATUS, 32'h0000_0080);
		rc(serial_bus_pkg::OFS_STATUS, 32'h0000_0080, 32'h0000_0000);
		moduleBusy <= 1'b0;
		acc(1'b1, serial_bus_pkg::OFS_TX_HOLD, 32'h0000_00A5);
		chk("txData", 32'h0000_01A5, {23'h0, txFull, txData});
		txTake <= 1'b1;
		@(posedge clk);
		txTake <= 1'b0;
		@(posedge clk);
		chk("txFull", 32'h0, {31'h0, txFull});
		finishTest;
	end
endmodule
